// ===== logic/scope_regs.vh
// Register map, field positions, reset values and timing counts of the capture scope
`ifndef SCOPE_REGS_VH
`define SCOPE_REGS_VH

`define OFS_CMD      8'h00
`define OFS_SETUP    8'h04
`define OFS_LEVEL    8'h08
`define OFS_PERIOD   8'h0C
`define OFS_CHAN     8'h10
`define OFS_TRIGSEL  8'h14
`define OFS_STATUS   8'h18
`define OFS_ISTAT    8'h1C
`define OFS_IMASK    8'h20
`define OFS_BADDR    8'h24
`define OFS_BDATA    8'h28
`define OFS_BGREQ    8'h2C
`define OFS_SNAP0    8'h30
`define OFS_SNAP3    8'h3C
`define OFS_PTRS     8'h40

`define CMD_ARM      0
`define CMD_RUN      1
`define CMD_STOP     2

`define SETUP_CONT   0
`define SETUP_EDGE_L 1
`define SETUP_EDGE_H 2
`define SETUP_POS_L  8
`define SETUP_POS_H  14

`define EDGE_IMM     2'h0
`define EDGE_RISE    2'h1
`define EDGE_FALL    2'h2

`define IRQ_TRIG     0
`define IRQ_DONE     1
`define IRQ_BG       2

`define ST_IDLE      3'h0
`define ST_RUN       3'h1
`define ST_ARMED     3'h2
`define ST_TRIG      3'h3
`define ST_DONE      3'h4

`define RST_SETUP    32'h00000000
`define RST_PERIOD   16'h0010
`define RST_CHAN     32'h00000000
`define RST_TRIGSEL  4'h0

`define BUF_WORDS    600
`define POS_MAX      7'h64
`define PERIOD_MIN   16'h0001
`define PERIOD_MAX   16'hFFF8

`define BASE_NS      125000
`define CLK_NS       50
`define BASE_CYCLES  (`BASE_NS / `CLK_NS)

`endif

// ===== logic/scope_tick.v
// Sample time base: one pulse every period times the base step
`timescale 1ns/10ps
`include "scope_regs.vh"
module scope_tick #(
    parameter BASE = `BASE_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        restart,
    input  wire [15:0] period,
    output reg         tick
);
    reg [11:0] base_cnt;
    reg [15:0] unit_cnt;
    wire       base_end = (base_cnt == BASE[11:0] - 12'h001);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= 12'h000;
            unit_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (restart) begin
            base_cnt <= 12'h000;
            unit_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (base_end) begin
                base_cnt <= 12'h000;
                // Period re-read each step, so changes take effect without a re-arm
                if (unit_cnt + 16'h0001 >= period) begin
                    unit_cnt <= 16'h0000;
                    tick     <= 1'b1;
                end else begin
                    unit_cnt <= unit_cnt + 16'h0001;
                end
            end else begin
                base_cnt <= base_cnt + 12'h001;
            end
        end
    end
endmodule // scope_tick

// ===== logic/scope_capture.v
// Trigger and capture scope with APB register access
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "scope_regs.vh"
module scope_capture #(
    parameter NUM_VARS = 16
) (
    input  wire                  pclk,
    input  wire                  presetn,
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [7:0]            paddr,
    input  wire [31:0]           pwdata,
    input  wire [NUM_VARS*32-1:0] var_bus,
    input  wire [NUM_VARS-1:0]   var_dword,
    output reg  [31:0]           prdata,
    output reg                   pready,
    output reg                   pslverr,
    output reg                   irq
);
    localparam S_IDLE  = 5'b00001;
    localparam S_RUN   = 5'b00010;
    localparam S_ARMED = 5'b00100;
    localparam S_TRIG  = 5'b01000;
    localparam S_DONE  = 5'b10000;

    reg  [4:0]  state;
    reg  [31:0] setup;
    reg  [31:0] level;
    reg  [15:0] period;
    reg  [31:0] chan;
    reg  [3:0]  trig_sel;
    reg  [2:0]  istat;
    reg  [2:0]  imask;
    reg  [9:0]  baddr;
    reg  [15:0] mem [0:`BUF_WORDS-1];
    reg  [31:0] snap [0:3];
    reg  [3:0]  en_l;
    reg  [3:0]  dw_l;
    reg  [3:0]  wps;
    reg  [9:0]  depth;
    reg  [9:0]  pre;
    reg  [9:0]  post_left;
    reg  [9:0]  filled;
    reg  [9:0]  total;
    reg  [9:0]  wr_ptr;
    reg  [9:0]  trig_ptr;
    reg  [2:0]  slot;
    reg         busy;
    reg         last;
    reg  [31:0] prev;
    reg         prev_ok;
    wire        tick;

    // Variable selected by a 4-bit index
    function [31:0] pick;
        input [NUM_VARS*32-1:0] bus;
        input [3:0]             sel;
        integer                 i;
        begin
            pick = 32'h00000000;
            for (i = 0; i < NUM_VARS; i = i + 1)
                if (sel == i[3:0])
                    pick = bus[i*32 +: 32];
        end
    endfunction

    // Entries per channel for a given number of words per sample
    function [9:0] depth_of;
        input [3:0] w;
        begin
            case (w)
                4'h1:    depth_of = 10'd600;
                4'h2:    depth_of = 10'd300;
                4'h3:    depth_of = 10'd200;
                4'h4:    depth_of = 10'd150;
                4'h5:    depth_of = 10'd120;
                4'h6:    depth_of = 10'd100;
                4'h7:    depth_of = 10'd85;
                4'h8:    depth_of = 10'd75;
                default: depth_of = 10'd0;
            endcase
        end
    endfunction

    wire        access = psel & penable & ~pready;
    wire        wr     = access & pwrite;
    wire        cmd_wr = wr && paddr == `OFS_CMD;
    wire        stop   = cmd_wr & pwdata[`CMD_STOP];
    wire        arm    = cmd_wr & pwdata[`CMD_ARM] & ~stop;
    wire        run    = cmd_wr & pwdata[`CMD_RUN] & ~stop & ~pwdata[`CMD_ARM];
    wire        bg_req = wr && paddr == `OFS_BGREQ && state == S_RUN;
    wire        w1c    = wr && paddr == `OFS_ISTAT;
    wire        cont   = setup[`SETUP_CONT];
    wire [1:0]  edge_s = setup[`SETUP_EDGE_H:`SETUP_EDGE_L];
    wire [6:0]  pos_r  = setup[`SETUP_POS_H:`SETUP_POS_L];
    wire [6:0]  pos    = (pos_r > `POS_MAX) ? `POS_MAX : pos_r;
    wire        rearm  = state == S_DONE && cont && w1c && pwdata[`IRQ_DONE];

    // Words per sample from the enabled channels, double words counting twice
    reg  [3:0]  next_wps;
    integer     k;
    always @* begin
        next_wps = 4'h0;
        for (k = 0; k < 4; k = k + 1)
            if (chan[8*k+7])
                next_wps = next_wps + (var_dword[chan[8*k +: 4]] ? 4'h2 : 4'h1);
    end
    wire [9:0]  next_depth = depth_of(next_wps);
    wire [16:0] pre_prod   = next_depth * pos;
    wire [16:0] pre_quot   = pre_prod / 17'd100;
    wire [9:0]  next_pre   = pre_quot[9:0];
    wire [15:0] depth_w    = next_depth * next_wps;

    // Trigger decision on the fresh sample
    wire [31:0] tv       = pick(var_bus, trig_sel);
    wire        pre_full = filled >= pre;
    wire        rise     = prev_ok && $signed(tv) > $signed(prev)
                           && $signed(tv) >= $signed(level);
    wire        fall     = prev_ok && $signed(tv) < $signed(prev)
                           && $signed(tv) <= $signed(level);
    reg         hit;
    always @* begin
        case (edge_s)
            `EDGE_RISE: hit = pre_full & rise;
            `EDGE_FALL: hit = pre_full & fall;
            default:    hit = pre_full;
        endcase
    end

    wire        do_arm     = arm | rearm;
    wire        smp_armed  = tick && state == S_ARMED && !busy;
    wire        smp_trig   = tick && state == S_TRIG && !busy && !last;
    wire        trig_now   = smp_armed && hit;
    wire        to_done    = trig_now && post_left == 10'd0;

    scope_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (do_arm),
        .period  (period),
        .tick    (tick)
    );

    // Capture state machine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
        end else if (stop) begin
            state <= S_IDLE;
        end else if (do_arm) begin
            state <= (next_wps == 4'h0) ? S_DONE : S_ARMED;
        end else if (run) begin
            state <= S_RUN;
        end else begin
            case (state)
                S_ARMED: if (trig_now)
                             state <= to_done ? S_DONE : S_TRIG;
                // Done only once the final sample's words are in the buffer
                S_TRIG:  if (busy && last && slot == 3'h7)
                             state <= S_DONE;
                S_IDLE,
                S_RUN,
                S_DONE:  state <= state;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Sample bookkeeping and buffer writer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_l      <= 4'h0;
            dw_l      <= 4'h0;
            wps       <= 4'h0;
            depth     <= 10'd0;
            pre       <= 10'd0;
            post_left <= 10'd0;
            filled    <= 10'd0;
            total     <= 10'd0;
            wr_ptr    <= 10'd0;
            trig_ptr  <= 10'd0;
            slot      <= 3'h0;
            busy      <= 1'b0;
            last      <= 1'b0;
            prev      <= 32'h00000000;
            prev_ok   <= 1'b0;
        end else if (do_arm) begin
            // Layout is frozen at arm so a channel change cannot tear the buffer
            en_l      <= {chan[31], chan[23], chan[15], chan[7]};
            dw_l      <= {var_dword[chan[27:24]], var_dword[chan[19:16]],
                          var_dword[chan[11:8]], var_dword[chan[3:0]]};
            wps       <= next_wps;
            depth     <= next_depth;
            pre       <= next_pre;
            post_left <= next_depth - next_pre;
            total     <= depth_w[9:0];
            filled    <= 10'd0;
            wr_ptr    <= 10'd0;
            slot      <= 3'h0;
            busy      <= 1'b0;
            last      <= 1'b0;
            prev_ok   <= 1'b0;
        end else begin
            if (smp_armed || smp_trig) begin
                prev    <= tv;
                prev_ok <= 1'b1;
            end
            if (smp_armed && !to_done) begin
                busy <= 1'b1;
                if (!trig_now && filled < depth)
                    filled <= filled + 10'd1;
                if (trig_now) begin
                    trig_ptr  <= wr_ptr;
                    post_left <= post_left - 10'd1;
                    last      <= post_left == 10'd1;
                end
            end
            if (smp_trig) begin
                busy      <= 1'b1;
                post_left <= post_left - 10'd1;
                last      <= post_left == 10'd1;
            end
            if (busy) begin
                slot <= slot + 3'h1;
                if (slot == 3'h7)
                    busy <= 1'b0;
                // Hidden flag is not consulted: every enabled channel is written
                if (en_l[slot[2:1]] && (!slot[0] || dw_l[slot[2:1]]))
                    wr_ptr <= (wr_ptr + 10'd1 >= total) ? 10'd0 : wr_ptr + 10'd1;
            end
        end
    end

    always @(posedge pclk) begin
        if (busy && en_l[slot[2:1]] && (!slot[0] || dw_l[slot[2:1]]))
            mem[wr_ptr] <= slot[0] ? snap[slot[2:1]][31:16] : snap[slot[2:1]][15:0];
    end

    // Channel snapshots: per tick when armed or triggered, per request when running
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_snap
            always @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    snap[g] <= 32'h00000000;
                else if (smp_armed || smp_trig || bg_req)
                    snap[g] <= pick(var_bus, chan[8*g +: 4]);
            end
        end
    endgenerate

    reg [2:0] code;
    always @* begin
        case (state)
            S_RUN:   code = `ST_RUN;
            S_ARMED: code = `ST_ARMED;
            S_TRIG:  code = `ST_TRIG;
            S_DONE:  code = `ST_DONE;
            default: code = `ST_IDLE;
        endcase
    end

    // Configuration registers and interrupt status
    wire stopped = state == S_IDLE || state == S_DONE;
    // Arming with no channel enabled completes at once and must still flag completion
    wire [2:0] ev = {bg_req, state == S_TRIG && busy && last && slot == 3'h7 || to_done
                     || (do_arm && next_wps == 4'h0), trig_now};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup    <= `RST_SETUP;
            level    <= 32'h00000000;
            period   <= `RST_PERIOD;
            chan     <= `RST_CHAN;
            trig_sel <= `RST_TRIGSEL;
            istat    <= 3'h0;
            imask    <= 3'h0;
            baddr    <= 10'd0;
            irq      <= 1'b0;
        end else begin
            if (wr && paddr == `OFS_SETUP)
                setup <= pwdata;
            if (wr && paddr == `OFS_LEVEL)
                level <= pwdata;
            if (wr && paddr == `OFS_PERIOD)
                period <= (pwdata[15:0] < `PERIOD_MIN) ? `PERIOD_MIN :
                          (pwdata[15:0] > `PERIOD_MAX) ? `PERIOD_MAX : pwdata[15:0];
            if (wr && paddr == `OFS_CHAN)
                chan <= pwdata;
            if (wr && paddr == `OFS_TRIGSEL && stopped)
                trig_sel <= pwdata[3:0];
            if (wr && paddr == `OFS_IMASK)
                imask <= pwdata[2:0];
            // A new event in the clearing cycle survives the clear
            istat <= (istat & ~(w1c ? pwdata[2:0] : 3'h0)) | ev;
            irq   <= |(((istat & ~(w1c ? pwdata[2:0] : 3'h0)) | ev) & imask);
            if (wr && paddr == `OFS_BADDR)
                baddr <= pwdata[9:0];
            else if (access && !pwrite && paddr == `OFS_BDATA)
                baddr <= (baddr == `BUF_WORDS - 1) ? 10'd0 : baddr + 10'd1;
        end
    end

    // APB answer: registered, one wait state on every access
    reg [31:0] rd;
    reg        bad;
    always @* begin
        bad = 1'b0;
        case (paddr)
            `OFS_CMD:     rd = 32'h00000000;
            `OFS_SETUP:   rd = setup;
            `OFS_LEVEL:   rd = level;
            `OFS_PERIOD:  rd = {16'h0000, period};
            `OFS_CHAN:    rd = chan;
            `OFS_TRIGSEL: rd = {28'h0000000, trig_sel};
            `OFS_STATUS:  rd = {6'h00, depth, 9'h000, wps, code};
            `OFS_ISTAT:   rd = {29'h00000000, istat};
            `OFS_IMASK:   rd = {29'h00000000, imask};
            `OFS_BADDR:   rd = {22'h000000, baddr};
            `OFS_BDATA:   rd = {16'h0000, mem[baddr]};
            `OFS_BGREQ:   rd = 32'h00000000;
            8'h30:        rd = snap[0];
            8'h34:        rd = snap[1];
            8'h38:        rd = snap[2];
            `OFS_SNAP3:   rd = snap[3];
            `OFS_PTRS:    rd = {6'h00, trig_ptr, 6'h00, wr_ptr};
            default: begin
                rd  = 32'h00000000;
                bad = 1'b1;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access;
            pslverr <= access & bad;
            prdata  <= (access && !pwrite) ? rd : 32'h00000000;
        end
    end

endmodule // scope_capture

// ===== tb/scope_capture_assertions.sv
// Bus-side checker for the capture scope
`timescale 1ns/10ps
`include "scope_regs.vh"
module scope_capture_checker #(
    parameter NUM_VARS = 16
) (
    input wire                    pclk,
    input wire                    presetn,
    input wire                    psel,
    input wire                    penable,
    input wire                    pwrite,
    input wire [7:0]              paddr,
    input wire [31:0]             pwdata,
    input wire [NUM_VARS*32-1:0]  var_bus,
    input wire [NUM_VARS-1:0]     var_dword,
    input wire [31:0]             prdata,
    input wire                    pready,
    input wire                    pslverr,
    input wire                    irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_rd_done;
        pready && !pwrite;
    endsequence
    property p_ready_after_take;
        s_take |=> pready;
    endproperty
    a_ready_after_take: assert property (p_ready_after_take) else $error("access not answered");
    property p_ready_cause;
        pready |-> $past(psel && penable && !pready) ##1 !pready;
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("stray or long ready");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_rdata_quiet;
        (!pready || pwrite) |-> prdata == 32'h0;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside read");
    property p_cmd_reads_zero;
        s_rd_done ##0 (paddr == `OFS_CMD) |-> prdata == 32'h0;
    endproperty
    a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command reads nonzero");
    property p_state_legal;
        s_rd_done ##0 (paddr == `OFS_STATUS) |-> prdata[2:0] <= `ST_DONE;
    endproperty
    a_state_legal: assert property (p_state_legal) else $error("illegal state code");
    property p_unmapped;
        s_take ##0 (paddr > `OFS_PTRS) |=> pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_mapped;
        s_take ##0 (paddr <= `OFS_PTRS && paddr[1:0] == 2'h0) |=> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_mask_off;
        s_take ##0 (pwrite && paddr == `OFS_IMASK && pwdata == 32'h0) |-> ##[1:3] !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq stays with mask off");
endmodule // scope_capture_checker

bind scope_capture scope_capture_checker #(.NUM_VARS(NUM_VARS)) u_scope_capture_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .var_bus(var_bus), .var_dword(var_dword), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

// ===== tb/host_link.sv
// Workstation-side APB master model
`timescale 1ns/10ps
module host_link (
    input  wire        pclk,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [7:0]  paddr,
    output reg  [31:0] pwdata,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Arm and stop are plain writes, so re-arming stays with the caller
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output err, output tmo);
        integer i;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            tmo = 1'b1;
            q = 32'h0;
            err = 1'b0;
            for (i = 0; i < 16 && tmo; i = i + 1) begin
                @(posedge pclk);
                if (pready === 1'b1) begin
                    tmo = 1'b0;
                    q = prdata;
                    err = pslverr;
                end
            end
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule // host_link

// ===== tb/tb.sv
// Self-checking bench for the capture scope
`timescale 1ns/10ps
`include "scope_regs.vh"
module tb;
    reg          pclk, presetn;
    wire         psel, penable, pwrite, pready, pslverr, irq;
    wire [7:0]   paddr;
    wire [31:0]  pwdata, prdata;
    reg  [511:0] var_bus;
    reg  [15:0]  var_dword;
    integer      n_mismatch, total_checks;
    reg  [31:0]  q;
    reg          rerr;

    scope_capture u_scope_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .var_bus(var_bus), .var_dword(var_dword),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    host_link u_host_link (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task final_report;
        begin
            if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // A hung bus ends the run at once, since later steps would all mislead
    task xf(input w, input [7:0] a, input [31:0] d);
        reg t;
        begin
            u_host_link.xfer(w, a, d, q, rerr, t);
            if (t) begin
                n_mismatch = n_mismatch + 1;
                final_report;
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge pclk);
        end
    endtask
    task set_var(input integer i, input [31:0] v);
        begin
            @(posedge pclk);
            var_bus[32*i +: 32] <= v;
        end
    endtask
    task chk_state(input [2:0] s);
        begin
            xf(1'b0, `OFS_STATUS, 32'h0);
            chk({29'h0, q[2:0]}, {29'h0, s});
        end
    endtask
    task chk_irq(input b);
        begin
            cyc(2);
            chk({31'h0, irq}, {31'h0, b});
        end
    endtask

    task t_reset;
        begin
            chk_state(`ST_IDLE);
            xf(1'b0, `OFS_SETUP, 32'h0);
            chk(q, `RST_SETUP);
            xf(1'b0, `OFS_PERIOD, 32'h0);
            chk(q, {16'h0, `RST_PERIOD});
            xf(1'b0, `OFS_CHAN, 32'h0);
            chk(q, `RST_CHAN);
            xf(1'b0, `OFS_TRIGSEL, 32'h0);
            chk(q, {28'h0, `RST_TRIGSEL});
            xf(1'b1, 8'h44, 32'hFFFFFFFF);
            xf(1'b0, 8'h44, 32'h0);
            chk({31'h0, rerr}, 32'h1);
        end
    endtask
    // Hidden channel on a word variable, samples only on request
    task t_run;
        begin
            xf(1'b1, `OFS_CHAN, 32'h000000C1);
            set_var(1, 32'h12345678);
            xf(1'b1, `OFS_CMD, 32'h2);
            chk_state(`ST_RUN);
            xf(1'b1, `OFS_BGREQ, 32'h0);
            xf(1'b0, `OFS_SNAP0, 32'h0);
            chk(q, 32'h12345678);
            xf(1'b1, `OFS_IMASK, 32'h4);
            chk_irq(1'b1);
            xf(1'b1, `OFS_IMASK, 32'h0);
            chk_irq(1'b0);
            xf(1'b1, `OFS_IMASK, 32'h4);
            chk_irq(1'b1);
            xf(1'b1, `OFS_ISTAT, 32'h4);
            chk_irq(1'b0);
            xf(1'b1, `OFS_CMD, 32'h4);
            chk_state(`ST_IDLE);
        end
    endtask
    // No channel enabled: each capture completes at once
    task t_zero(input cont, input exp_again);
        begin
            xf(1'b1, `OFS_CHAN, 32'h0);
            xf(1'b1, `OFS_ISTAT, 32'h7);
            xf(1'b1, `OFS_SETUP, {31'h0, cont});
            xf(1'b1, `OFS_CMD, 32'h1);
            chk_state(`ST_DONE);
            xf(1'b1, `OFS_ISTAT, 32'h2);
            cyc(4);
            xf(1'b0, `OFS_ISTAT, 32'h0);
            chk({31'h0, q[1]}, {31'h0, exp_again});
            xf(1'b1, `OFS_CMD, 32'h4);
            chk_state(`ST_IDLE);
        end
    endtask
    // Trigger on variable 2 with three samples v0, v1, v2
    task t_edge(input [1:0] e, input [31:0] lvl, chan, input [3:0] w, input [31:0] v0, v1, v2, input [2:0] mid);
        begin
            xf(1'b1, `OFS_CHAN, chan);
            xf(1'b1, `OFS_TRIGSEL, 32'h2);
            xf(1'b1, `OFS_PERIOD, 32'h1);
            xf(1'b1, `OFS_LEVEL, lvl);
            xf(1'b1, `OFS_SETUP, {29'h0, e, 1'b0});
            set_var(2, v0);
            xf(1'b1, `OFS_CMD, 32'h1);
            cyc(3750);
            set_var(2, v1);
            cyc(2500);
            chk_state(mid);
            set_var(2, v2);
            cyc(2500);
            xf(1'b0, `OFS_STATUS, 32'h0);
            chk({29'h0, q[2:0]}, {29'h0, `ST_TRIG});
            chk({28'h0, q[6:3]}, {28'h0, w});
            chk({22'h0, q[25:16]}, `BUF_WORDS / w);
            xf(1'b0, `OFS_PTRS, 32'h0);
            chk({22'h0, q[25:16]}, (mid == `ST_TRIG) ? 32'h0 : 2 * w);
            chk({22'h0, q[9:0]}, 3 * w);
            xf(1'b1, `OFS_BADDR, (mid == `ST_TRIG) ? 32'h0 : 32'h2);
            xf(1'b0, `OFS_BDATA, 32'h0);
            chk(q, (mid == `ST_TRIG) ? 32'h0 : {16'h0, v2[15:0]});
            xf(1'b1, `OFS_TRIGSEL, 32'h5);
            xf(1'b0, `OFS_TRIGSEL, 32'h0);
            chk(q, 32'h2);
            xf(1'b1, `OFS_CMD, 32'h4);
            chk_state(`ST_IDLE);
        end
    endtask

    initial begin
        presetn = 1'b0;
        var_bus = 512'h0;
        var_dword = 16'h0008;
        n_mismatch = 0;
        total_checks = 0;
        cyc(4);
        presetn <= 1'b1;
        t_reset;
        t_run;
        t_zero(1'b1, 1'b1);
        t_zero(1'b0, 1'b0);
        t_edge(`EDGE_IMM, 32'h0, 32'h83838383, 4'h8, 32'h0, 32'h0, 32'h0, `ST_TRIG);
        t_edge(`EDGE_RISE, 32'hFFFFFFFB, 32'h00000082, 4'h1, 32'hFFFFFFF6, 32'hFFFFFFF8, 32'hFFFFFFFD, `ST_ARMED);
        t_edge(`EDGE_RISE, 32'h7FFFFFFF, 32'h00000082, 4'h1, 32'h0, 32'h7FFFFFFE, 32'h7FFFFFFF, `ST_ARMED);
        t_edge(`EDGE_FALL, 32'h80000000, 32'h00000082, 4'h1, 32'h0, 32'h80000001, 32'h80000000, `ST_ARMED);
        final_report;
    end
endmodule // tb
